// ===== character_video_defines.svh
// offsets, field positions, reset values and timing defaults of the character video generator
`ifndef CHARACTER_VIDEO_DEFINES_SVH
`define CHARACTER_VIDEO_DEFINES_SVH

// ============================================================
// register byte offsets
`define REG_CONTROL_OFS    8'h00
`define REG_CURSOR_COL_OFS 8'h04
`define REG_CURSOR_ROW_OFS 8'h08
`define REG_RAM_PTR_OFS    8'h0C
`define REG_RAM_DATA_OFS   8'h10
`define REG_STATUS_OFS     8'h14
`define REG_CG_PTR_OFS     8'h18
`define REG_CG_DATA_OFS    8'h1C

// ============================================================
// control latch fields and reset value
`define CTL_GATE_BIT       7
`define CTL_REVERSE_BIT    6
`define CTL_BLANK_ALL_BIT  5
`define CTL_BLINK_ENH_BIT  4
`define CTL_UNDERLINE_BIT  2
`define CTL_RESET          8'h80

// ============================================================
// cell and scan constants
`define DOTS_PER_CELL      9
`define DOTS_LOADED        8
`define CURSOR_SCAN_ROW    4'h9
`define BLINK_BITS         5

// ============================================================
// timing defaults, in characters and scan lines
`define H_TOTAL_DEF        100
`define H_ACTIVE_DEF       80
`define H_SYNC_START_DEF   84
`define H_SYNC_LEN_DEF     8
`define SCANS_PER_ROW_DEF  12
`define V_ROWS_DEF         24
`define V_TOTAL_DEF        300
`define V_SYNC_START_DEF   292
`define V_SYNC_LEN_DEF     4

`endif

// ===== character_video_generator.sv
// character cell video generator with shared display RAM and scan timing
// Operation
// - character clock carry loads shift register, flag latch and RAM latch together
// - shift register loads eight dots; last output recirculates, ninth dot repeats first
// - shift register shifts every dot clock but the carry, which loads it; its output is raw dot video
// - RAM address is seven column bits low and five row bits high
// - generator address is scan row low and seven RAM byte bits high
// - RAM byte is captured in a latch by character clock before generator
// - scan controller produces blanking, composite, vertical, horizontal sync and cursor
// - composite sync gated by control bit forms active-low bus request
// - processor acknowledges; acknowledge hands RAM buses to the scan controller
// - request withdrawn during sync pulse; processor then regains RAM
// - gate bit written low masks request so processor never stalls
// - five-bit counter on vertical sync divides by 32 to give blink
// - RAM byte top bit is the enhancement flag, latched with shift load
// - latch bit 7 gates request, 5 blanks all, 6 reverses enhanced; 2 unused
// - dot video inverted, passes an exclusive-OR selective inverter, then is inverted again
// - video blanked in vertical sync and horizontal blanking
// - video blanked by enhancement flag with blinking enhancement bit
// - blink, cursor position and scan row 9 force reversal: blinking underline cursor
// - enhancement flag with reverse enhancement selected forces reversal
// - output combines composite sync with gated dot video
// - character clock is dot clock divided by nine
`timescale 1ns/10ps
`include "character_video_defines.svh"

module character_video_generator
  import character_video_pkg::*;
#(
  parameter int H_TOTAL       = `H_TOTAL_DEF,
  parameter int H_ACTIVE      = `H_ACTIVE_DEF,
  parameter int H_SYNC_START  = `H_SYNC_START_DEF,
  parameter int H_SYNC_LEN    = `H_SYNC_LEN_DEF,
  parameter int SCANS_PER_ROW = `SCANS_PER_ROW_DEF,
  parameter int V_ROWS        = `V_ROWS_DEF,
  parameter int V_TOTAL       = `V_TOTAL_DEF,
  parameter int V_SYNC_START  = `V_SYNC_START_DEF,
  parameter int V_SYNC_LEN    = `V_SYNC_LEN_DEF
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        bus_acknowledge_in,
  output logic             bus_request_n_out,
  output logic             dot_video_out,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             csync_n_out,
  output logic             blank_out,
  output logic             cursor_out,
  output logic [1:0]       composite_level_out
);

  // ============================================================
  // storage
  byte_t     display_ram [0:4095];
  byte_t     char_gen    [0:2047];
  byte_t     ctrl_q;
  column_t   cur_col_q;
  char_row_t cur_row_q;
  ram_addr_t ram_ptr_q;
  cg_addr_t  cg_ptr_q;
  byte_t     ram_rd_q;

  // ============================================================
  // scan state
  logic [3:0]  dot_cnt_q;
  logic        carry;
  column_t     col_q;
  scan_t       scan_q;
  char_row_t   crow_q;
  logic [8:0]  line_q;
  logic        hblank_c, hsync_c, vblank_c, vsync_c, csync_c;
  logic [1:0]  hblank_pipe_q, cursor_pipe_q;
  ram_addr_t   scan_addr;
  ram_addr_t   ram_addr;
  byte_t       ram_data_q;
  byte_t       dots_q;
  logic        enh_q;
  logic [`BLINK_BITS-1:0] blink_cnt_q;
  logic        vsync_prev_q;
  logic        blink;
  logic        reverse, blank_all, inv_dot, sel_dot, pix;

  // ============================================================
  // wishbone decode
  logic req, wr, rd;
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr  = req && wb_we_in && wb_sel_in[0];
  assign rd  = req && !wb_we_in;

  // one wait-free cycle: ack follows the request by one edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  // control and pointer registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_q    <= `CTL_RESET;
      cur_col_q <= '0;
      cur_row_q <= '0;
      ram_ptr_q <= '0;
      cg_ptr_q  <= '0;
    end else if (wr) begin
      if (wb_adr_in == `REG_CONTROL_OFS) begin
        ctrl_q <= wb_dat_in[7:0];
      end else if (wb_adr_in == `REG_CURSOR_COL_OFS) begin
        cur_col_q <= wb_dat_in[6:0];
      end else if (wb_adr_in == `REG_CURSOR_ROW_OFS) begin
        cur_row_q <= wb_dat_in[4:0];
      end else if (wb_adr_in == `REG_RAM_PTR_OFS && wb_sel_in[1]) begin
        ram_ptr_q <= wb_dat_in[11:0];
      end else if (wb_adr_in == `REG_RAM_DATA_OFS && !bus_acknowledge_in) begin
        ram_ptr_q <= ram_ptr_q + 12'h001;  // step after each stored byte
      end else if (wb_adr_in == `REG_CG_PTR_OFS && wb_sel_in[1]) begin
        cg_ptr_q <= wb_dat_in[10:0];
      end else if (wb_adr_in == `REG_CG_DATA_OFS) begin
        cg_ptr_q <= cg_ptr_q + 11'h001;
      end
    end
  end

  // read mux; control latch is write-only and reads zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wb_dat_out <= '0;
    end else if (rd) begin
      if (wb_adr_in == `REG_CURSOR_COL_OFS) begin
        wb_dat_out <= {25'h0, cur_col_q};
      end else if (wb_adr_in == `REG_CURSOR_ROW_OFS) begin
        wb_dat_out <= {27'h0, cur_row_q};
      end else if (wb_adr_in == `REG_RAM_PTR_OFS) begin
        wb_dat_out <= {20'h0, ram_ptr_q};
      end else if (wb_adr_in == `REG_RAM_DATA_OFS) begin
        wb_dat_out <= {24'h0, ram_rd_q};
      end else if (wb_adr_in == `REG_STATUS_OFS) begin
        wb_dat_out <= {20'h0, blink_cnt_q, 2'h0, vsync_out, hsync_out,
                       bus_acknowledge_in, bus_request_n_out, blink};
      end else if (wb_adr_in == `REG_CG_PTR_OFS) begin
        wb_dat_out <= {21'h0, cg_ptr_q};
      end else begin
        wb_dat_out <= '0;
      end
    end else begin
      wb_dat_out <= '0;
    end
  end

  // ============================================================
  // character clock: divide the dot clock by nine
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dot_cnt_q <= '0;
    end else if (carry) begin
      dot_cnt_q <= '0;
    end else begin
      dot_cnt_q <= dot_cnt_q + 4'h1;
    end
  end
  assign carry = (dot_cnt_q == 4'(`DOTS_PER_CELL - 1));

  // ============================================================
  // scan controller counters, stepping across and down
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      col_q  <= '0;
      scan_q <= '0;
      crow_q <= '0;
      line_q <= '0;
    end else if (carry) begin
      if (32'(col_q) == H_TOTAL - 1) begin
        col_q <= '0;
        if (32'(line_q) == V_TOTAL - 1) begin
          line_q <= '0;
          scan_q <= '0;
          crow_q <= '0;
        end else begin
          line_q <= line_q + 9'h001;
          if (32'(scan_q) == SCANS_PER_ROW - 1) begin
            scan_q <= '0;
            crow_q <= crow_q + 5'h01;
          end else begin
            scan_q <= scan_q + 4'h1;
          end
        end
      end else begin
        col_q <= col_q + 7'h01;
      end
    end
  end

  // timing decode
  assign hblank_c  = (32'(col_q) >= H_ACTIVE);
  assign hsync_c   = (32'(col_q) >= H_SYNC_START) && (32'(col_q) < H_SYNC_START + H_SYNC_LEN);
  assign vblank_c  = (32'(line_q) >= V_ROWS * SCANS_PER_ROW);
  assign vsync_c   = (32'(line_q) >= V_SYNC_START) && (32'(line_q) < V_SYNC_START + V_SYNC_LEN);
  assign csync_c   = hsync_c ^ vsync_c;
  assign scan_addr = {crow_q, col_q};

  // sync, blank and cursor outputs of the scan controller
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hsync_out   <= 1'b0;
      vsync_out   <= 1'b0;
      csync_n_out <= 1'b1;
      blank_out   <= 1'b1;
      cursor_out  <= 1'b0;
    end else begin
      hsync_out   <= hsync_c;
      vsync_out   <= vsync_c;
      csync_n_out <= !csync_c;
      blank_out   <= hblank_c || vblank_c;
      cursor_out  <= (col_q == cur_col_q) && (crow_q == cur_row_q);
    end
  end

  // ============================================================
  // bus request: asserted outside sync while the gate bit is high
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bus_request_n_out <= 1'b1;
    end else begin
      bus_request_n_out <= !(ctrl_q[`CTL_GATE_BIT] && !csync_c);
    end
  end

  // ============================================================
  // RAM address multiplexer and shared memory
  assign ram_addr = bus_acknowledge_in ? scan_addr : ram_ptr_q;

  always_ff @(posedge clk_in) begin
    ram_rd_q <= display_ram[ram_addr];
    if (wr && wb_adr_in == `REG_RAM_DATA_OFS && !bus_acknowledge_in) begin
      display_ram[ram_ptr_q] <= wb_dat_in[7:0];  // processor owns RAM only without ack
    end
    if (wr && wb_adr_in == `REG_CG_DATA_OFS) begin
      char_gen[cg_ptr_q] <= wb_dat_in[7:0];
    end
  end

  // ============================================================
  // cell loads on the character clock carry
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ram_data_q <= '0;
      dots_q     <= '0;
      enh_q      <= 1'b0;
    end else if (carry) begin
      ram_data_q <= ram_rd_q;
      dots_q     <= char_gen[{ram_data_q[6:0], scan_q}];
      enh_q      <= ram_data_q[7];
    end else begin
      dots_q <= {dots_q[`DOTS_LOADED-2:0], dots_q[`DOTS_LOADED-1]};
    end
  end

  // align blank and cursor with the two-cell load pipeline
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hblank_pipe_q <= 2'h3;
      cursor_pipe_q <= 2'h0;
    end else if (carry) begin
      hblank_pipe_q <= {hblank_pipe_q[0], hblank_c};
      cursor_pipe_q <= {cursor_pipe_q[0], (col_q == cur_col_q) && (crow_q == cur_row_q)};
    end
  end

  // ============================================================
  // blink counter advances on each vertical sync rising edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      vsync_prev_q <= 1'b0;
      blink_cnt_q  <= '0;
    end else begin
      vsync_prev_q <= vsync_c;
      if (vsync_c && !vsync_prev_q) begin
        blink_cnt_q <= blink_cnt_q + 5'h01;
      end
    end
  end
  assign blink = blink_cnt_q[`BLINK_BITS-1];

  // ============================================================
  // reversal, selective inversion and blanking
  assign reverse   = (blink && cursor_pipe_q[1] && scan_q == `CURSOR_SCAN_ROW)
                   || (enh_q && ctrl_q[`CTL_REVERSE_BIT]);
  assign blank_all = vsync_c || hblank_pipe_q[1] || vblank_c
                   || (enh_q && ctrl_q[`CTL_BLINK_ENH_BIT] && blink)
                   || ctrl_q[`CTL_BLANK_ALL_BIT];
  assign inv_dot   = !dots_q[`DOTS_LOADED-1];
  assign sel_dot   = inv_dot ^ reverse;
  assign pix       = !sel_dot && !blank_all;

  // video and composite mix: 0 sync, 1 black, 2 white
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dot_video_out       <= 1'b0;
      composite_level_out <= 2'h1;
    end else begin
      dot_video_out <= pix;
      if (csync_c) begin
        composite_level_out <= 2'h0;
      end else if (pix) begin
        composite_level_out <= 2'h2;
      end else begin
        composite_level_out <= 2'h1;
      end
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_carry_period;
    carry |=> !carry [*8] ##1 carry;
  endproperty
  a_carry_period: assert property (p_carry_period) else $error("cell not nine dots");

  property p_shift;
    !carry ##1 !carry |-> dots_q[0] === $past(dots_q[7]);
  endproperty
  a_shift: assert property (p_shift) else $error("dots not recirculated");

  property p_latch_load;
    carry |=> ram_data_q === $past(ram_rd_q) && enh_q === $past(ram_data_q[7]);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_latch_hold;
    !carry |=> ram_data_q === $past(ram_data_q) && enh_q === $past(enh_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed mid cell");

  property p_req_sync;
    csync_c |=> bus_request_n_out;
  endproperty
  a_req_sync: assert property (p_req_sync) else $error("request held in sync");

  property p_req_mask;
    !ctrl_q[`CTL_GATE_BIT] |=> bus_request_n_out;
  endproperty
  a_req_mask: assert property (p_req_mask) else $error("request not masked");

  property p_req_on;
    ctrl_q[`CTL_GATE_BIT] && !csync_c |=> !bus_request_n_out;
  endproperty
  a_req_on: assert property (p_req_on) else $error("request missing");

  property p_blank;
    (vsync_c || ctrl_q[`CTL_BLANK_ALL_BIT]) |=> !dot_video_out;
  endproperty
  a_blank: assert property (p_blank) else $error("video not blanked");

  property p_sync_level;
    csync_c |=> composite_level_out == 2'h0;
  endproperty
  a_sync_level: assert property (p_sync_level) else $error("sync not mixed");

  property p_blink_step;
    vsync_c && !vsync_prev_q |=> blink_cnt_q == $past(blink_cnt_q) + 5'h01;
  endproperty
  a_blink_step: assert property (p_blink_step) else $error("blink count stuck");

  property p_reverse;
    !blank_all && enh_q && ctrl_q[`CTL_REVERSE_BIT] |=> dot_video_out == !$past(dots_q[7]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("enhanced not reversed");

  c_request: cover property (!bus_request_n_out ##1 bus_request_n_out);
  c_cursor:  cover property (blink && cursor_pipe_q[1] && scan_q == `CURSOR_SCAN_ROW);
  c_pixel:   cover property (dot_video_out);

endmodule

// ===== character_video_generator_fix_note_unused.sv
`timescale 1ns/10ps

// ===== character_video_generator_tb.sv
// self-checking bench for the character video generator
`timescale 1ns/10ps
`include "character_video_defines.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, s); end end

module character_video_generator_tb;
  localparam int HT = 20, HA = 12, HL = 2, SC = 12, VR = 2, VT = 30, VL = 2;
  localparam int D = `DOTS_PER_CELL;
  localparam int FRAME = HT * D * VT;
  localparam int HSYNC = HL * D * VT;
  localparam int VSYNC = VL * HT * D;
  localparam int CSYNC = HSYNC + VSYNC - 2 * HL * D * VL;
  localparam int BLANK = FRAME - HA * D * VR * SC;
  localparam int LIT   = HA * VR * SC * 3;

  logic        clk_in = 1'b0, srst_in = 1'b1, slow = 1'b0;
  logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, q, s1;
  logic [31:0] wb_dat_out;
  logic [1:0]  composite_level_out;
  logic        wb_ack_out, bus_acknowledge_in, bus_request_n_out, dot_video_out;
  logic        hsync_out, vsync_out, csync_n_out, blank_out, cursor_out;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  int          k[10];

  character_video_generator #(.H_TOTAL(HT), .H_ACTIVE(HA), .H_SYNC_START(14),
    .H_SYNC_LEN(HL), .SCANS_PER_ROW(SC), .V_ROWS(VR), .V_TOTAL(VT), .V_SYNC_START(26),
    .V_SYNC_LEN(VL)) u_character_video_generator (
    .clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .bus_acknowledge_in(bus_acknowledge_in), .bus_request_n_out(bus_request_n_out),
    .dot_video_out(dot_video_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .csync_n_out(csync_n_out), .blank_out(blank_out), .cursor_out(cursor_out),
    .composite_level_out(composite_level_out));

  processor_bus_model u_processor_bus_model (.clk_in(clk_in), .srst_in(srst_in),
    .bus_request_n_in(bus_request_n_out), .slow_in(slow),
    .bus_acknowledge_out(bus_acknowledge_in));

  // ============================================================
  // clock and watchdog
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      $display("BAD watchdog expected done seen hang");
      end_of_test();
    end
  end

  // ============================================================
  // tasks
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  // count output activity over one whole frame, vsync rise to vsync rise
  task automatic frame;
    logic pv;
    @(posedge clk_in iff vsync_out === 1'b0);
    @(posedge clk_in iff vsync_out === 1'b1);
    k = '{default: 0};
    pv = 1'b1;
    while (!(vsync_out === 1'b1 && pv === 1'b0)) begin
      k[0] += int'(dot_video_out === 1'b1);
      k[1] += int'(composite_level_out === 2'h2);
      k[2] += int'(composite_level_out === 2'h0);
      k[3] += int'(bus_request_n_out === 1'b1);
      k[4] += int'(hsync_out === 1'b1);
      k[5] += int'(blank_out === 1'b1);
      k[6] += int'(csync_n_out === 1'b0);
      k[8] += int'(vsync_out === 1'b1);
      k[9] += int'(cursor_out === 1'b1);
      k[7]++;
      pv = vsync_out;
      @(posedge clk_in);
    end
  endtask

  task automatic chk_frame(input int lit, input int req);
    frame();
    `CHK("lit dots", lit, k[0])
    `CHK("white level", lit, k[1])
    `CHK("sync level", CSYNC, k[2])
    `CHK("request high", req, k[3])
    `CHK("hsync", HSYNC, k[4])
    `CHK("blank", BLANK, k[5])
    `CHK("csync", CSYNC, k[6])
    `CHK("frame", FRAME, k[7])
    `CHK("vsync", VSYNC, k[8])
    `CHK("cursor", D * SC, k[9])
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ============================================================
  // tests
  initial begin
    repeat (20) @(posedge clk_in);
    `CHK("reset request", 1'b1, bus_request_n_out)
    `CHK("reset level", 2'h1, composite_level_out)
    srst_in <= 1'b0;
    wb(1'b0, `REG_CONTROL_OFS, 32'h0);
    `CHK("control read", 32'h0, q)
    wr(8'h20, 32'hFF);
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    $display("test registers done");
    // gate off, then fill the screen with char 1 and its dot pattern
    wr(`REG_CONTROL_OFS, 32'h0);
    wr(`REG_CURSOR_COL_OFS, 32'h00);  // cursor on the first cell of row 0
    for (int r = 0; r < VR; r++) begin
      wr(`REG_RAM_PTR_OFS, 32'(r * 128));
      for (int c = 0; c < HA; c++) wr(`REG_RAM_DATA_OFS, 32'h01);
    end
    wr(`REG_CG_PTR_OFS, 32'h10);
    for (int s = 0; s < SC; s++) wr(`REG_CG_DATA_OFS, 32'h81);
    wr(`REG_RAM_PTR_OFS, 32'h83);
    wb(1'b0, `REG_RAM_DATA_OFS, 32'h0);
    `CHK("ram byte", 32'h01, q[7:0])
    chk_frame(LIT, FRAME);
    $display("test gate off done");
    wr(`REG_CONTROL_OFS, 32'h80);
    chk_frame(LIT, CSYNC);
    $display("test gate on done");
    // a write while the scan controller owns the RAM must not land
    slow <= 1'b1;
    wr(`REG_RAM_PTR_OFS, 32'h0);
    // wait for a fresh acknowledge so the write lands well inside it
    @(posedge clk_in iff bus_acknowledge_in === 1'b0);
    @(posedge clk_in iff bus_acknowledge_in === 1'b1);
    wr(`REG_RAM_DATA_OFS, 32'h81);
    wr(`REG_CONTROL_OFS, 32'h0);
    @(posedge clk_in iff bus_acknowledge_in === 1'b0);
    wr(`REG_RAM_PTR_OFS, 32'h0);
    wb(1'b0, `REG_RAM_DATA_OFS, 32'h0);
    `CHK("owned ram", 32'h01, q[7:0])
    $display("test ownership done");
    // one enhanced cell in reverse video: 6 of 9 dots lit instead of 3
    wr(`REG_RAM_PTR_OFS, 32'h0);
    wr(`REG_RAM_DATA_OFS, 32'h81);
    wr(`REG_CONTROL_OFS, 32'hC0);  // gate on so the scan controller reads the RAM
    chk_frame(LIT + SC * 3, CSYNC);
    $display("test reverse done");
    wr(`REG_CONTROL_OFS, 32'h60);
    chk_frame(0, FRAME);
    $display("test blank all done");
    // blink counter steps once per frame, blink is its top bit
    repeat (200) @(posedge clk_in);
    wb(1'b0, `REG_STATUS_OFS, 32'h0);
    s1 = q;
    frame();
    repeat (200) @(posedge clk_in);
    wb(1'b0, `REG_STATUS_OFS, 32'h0);
    `CHK("blink count", 5'h02, 5'(q[11:7] - s1[11:7]))
    `CHK("blink bit", q[11], q[0])
    $display("test blink done");
    end_of_test();
  end
endmodule

// ===== character_video_pkg.sv
// types shared by the character video generator
package character_video_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [6:0]  column_t;
  typedef logic [4:0]  char_row_t;
  typedef logic [3:0]  scan_t;
  typedef logic [11:0] ram_addr_t;
  typedef logic [10:0] cg_addr_t;
endpackage

// ===== processor_bus_model.sv
// behavioural model of the display processor that answers the bus request
`timescale 1ns/10ps

module processor_bus_model (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic bus_request_n_in,
  input  wire logic slow_in,
  output logic      bus_acknowledge_out
);
  logic [3:0] wait_q;

  // ============================================================
  // handshake
  // count the answer delay while the request is held, zero when withdrawn
  always_ff @(posedge clk_in) begin
    if (srst_in || bus_request_n_in) begin
      wait_q <= 4'h0;
    end else if (wait_q != 4'hF) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // acknowledge after a short or long suspend, drop it once the request goes
  always_ff @(posedge clk_in) begin
    if (srst_in || bus_request_n_in) begin
      bus_acknowledge_out <= 1'b0;
    end else if (wait_q >= (slow_in ? 4'h3 : 4'h0)) begin
      bus_acknowledge_out <= 1'b1;
    end
  end
endmodule
